// ==== verilog/ahtc_pkg.sv ====
// Package with constants and carrier types for the angle hysteresis and turns counter
package ahtc_pkg;
    // ============================================================
    // Widths
    localparam int ANGLE14_W = 14;
    localparam int ANGLE12_W = 12;
    localparam int ACC_W = 21;
    localparam int TURNS_W = 12;
    localparam int HYS_W = 6;
    // ============================================================
    // Register offsets
    localparam logic [5:0] TURN_COUNT_READOUT_OFFSET = 6'h2C;
    // ============================================================
    // Field positions and counts
    localparam int TURNS_LSB_180 = 11;
    localparam int TURNS_LSB_45 = 9;
    localparam logic [ACC_W-1:0] CODES_PER_TURN_180 = 21'h00_0800;
    localparam logic [ACC_W-1:0] CODES_PER_TURN_45 = 21'h00_0200;
    // ============================================================
    // Reset values
    localparam logic RESET_DIRECTION = 1'b0;
    localparam logic [ANGLE14_W-1:0] RESET_ANGLE = 14'h0000;
    localparam logic [ACC_W-1:0] RESET_ACC = 21'h00_0000;
    // Start modes
    typedef enum logic [1:0]
    {
        START_ZERO_A = 2'b00,
        START_ZERO_B = 2'b01,
        START_ANGLE = 2'b10,
        START_BOUNDARY = 2'b11
    } ahtc_start_type;
    // Sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_INIT = 2'b01,
        ST_RUN = 2'b10
    } ahtc_state_type;
    // Whole block state
    typedef struct packed
    {
        ahtc_state_type state;
        logic head_direction;
        logic [ANGLE14_W-1:0] head_angle;
        logic [ANGLE14_W-1:0] held_angle;
        logic [ANGLE14_W-1:0] prev_angle;
        logic [ACC_W-1:0] acc;
        logic [TURNS_W-1:0] turns;
        logic [23:0] total_position;
        logic [11:0] held_angle_out;
    } ahtc_regs_type;
endpackage : ahtc_pkg

// ==== verilog/ahtc_core.sv ====
// Angle hysteresis stage and multi-turn position accumulator
`timescale 1ns/10ps
module ahtc_core
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic clock_enable,
    input wire logic builtin_logic_selftest,
    input wire logic angle_valid,
    input wire logic [13:0] compensated_angle,
    input wire logic [13:0] zero_cross_path,
    input wire logic turns_source_select,
    input wire logic [5:0] hysteresis_width,
    input wire logic [1:0] start_mode,
    input wire logic fine_turn_mode,
    input wire logic [5:0] reg_address,
    output logic [13:0] angle_out,
    output logic [11:0] held_angle_out,
    output logic head_direction,
    output logic [20:0] position_accumulator,
    output logic [11:0] turn_count_readout,
    output logic [23:0] total_position,
    output logic [15:0] reg_read_data,
    output logic running
);
    // ============================================================
    // State
    ahtc_pkg::ahtc_regs_type r;
    ahtc_pkg::ahtc_regs_type next_r;
    logic [13:0] turn_angle;
    logic [13:0] hys_delta;
    logic [13:0] turn_delta;
    logic [13:0] tail_angle;
    logic [20:0] next_acc_calc;
    logic [20:0] init_acc;
    logic [11:0] turns_calc;
    logic [11:0] angle12;

    // Turn source selection
    assign turn_angle = turns_source_select ? compensated_angle : zero_cross_path;

    // Signed wrap-around differences, two's complement modulo 2^14
    assign hys_delta = compensated_angle - r.head_angle;
    assign turn_delta = turn_angle - r.prev_angle;
    assign next_acc_calc = r.acc + {{9{turn_delta[13]}}, turn_delta[13:2]};

    // Window tail opposite the head
    always_comb
    begin
        tail_angle = r.head_direction ?
            (r.head_angle + {8'h00, hysteresis_width}) :
            (r.head_angle - {8'h00, hysteresis_width});
    end

    // Accumulator start value per start mode
    always_comb
    begin
        init_acc = ahtc_pkg::RESET_ACC;
        case (ahtc_pkg::ahtc_start_type'(start_mode))
            ahtc_pkg::START_ZERO_A: init_acc = ahtc_pkg::RESET_ACC;
            ahtc_pkg::START_ZERO_B: init_acc = ahtc_pkg::RESET_ACC;
            ahtc_pkg::START_ANGLE: init_acc = {9'h000, turn_angle[13:2]};
            ahtc_pkg::START_BOUNDARY:
            begin
                // Offset past nearest lower 180 or 45 degree boundary
                if (fine_turn_mode)
                    init_acc = {12'h000, turn_angle[10:2]};
                else
                    init_acc = {10'h000, turn_angle[12:2]};
            end
            default: init_acc = ahtc_pkg::RESET_ACC;
        endcase
    end

    // Turn count extraction, sign-extended in coarse mode
    always_comb
    begin
        if (fine_turn_mode)
            turns_calc = next_r.acc[20:9];
        else
            turns_calc = {{2{next_r.acc[20]}}, next_r.acc[20:11]};
    end

    // Next-state logic
    always_comb
    begin
        next_r = r;
        case (r.state)
            ahtc_pkg::ST_IDLE:
            begin
                if (angle_valid)
                    next_r.state = ahtc_pkg::ST_INIT;
            end
            ahtc_pkg::ST_INIT:
            begin
                if (angle_valid)
                begin
                    // Window sits behind the first angle, direction increasing
                    next_r.head_direction = ahtc_pkg::RESET_DIRECTION;
                    next_r.head_angle = compensated_angle;
                    next_r.held_angle = compensated_angle;
                    next_r.prev_angle = turn_angle;
                    next_r.acc = init_acc;
                    next_r.state = ahtc_pkg::ST_RUN;
                end
            end
            ahtc_pkg::ST_RUN:
            begin
                if (angle_valid)
                begin
                    next_r.prev_angle = turn_angle;
                    next_r.acc = next_acc_calc;
                    if (!r.head_direction && !hys_delta[13] && hys_delta != 14'h0000)
                    begin
                        // Advancing in reference direction
                        next_r.head_angle = compensated_angle;
                        next_r.held_angle = compensated_angle;
                    end
                    else if (r.head_direction && hys_delta[13])
                    begin
                        next_r.head_angle = compensated_angle;
                        next_r.held_angle = compensated_angle;
                    end
                    else if ((r.head_direction ?
                        (compensated_angle - tail_angle) :
                        (tail_angle - compensated_angle)) < 14'h2000 &&
                        compensated_angle != tail_angle)
                    begin
                        // Left beyond tail: flip head and direction
                        next_r.head_direction = ~r.head_direction;
                        next_r.head_angle = compensated_angle;
                        next_r.held_angle = compensated_angle;
                    end
                    // Inside window head and output hold
                end
            end
            default: next_r.state = ahtc_pkg::ST_IDLE;
        endcase
        next_r.turns = turns_calc;
        angle12 = next_r.held_angle[13:2];
        next_r.held_angle_out = angle12;
        // Revolutions take the accumulator sign, not a turn-count bit
        next_r.total_position = {{3{next_r.acc[20]}},
            next_r.acc[20:12], angle12};
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rstn || builtin_logic_selftest)
        begin
            r.state <= ahtc_pkg::ST_INIT;
            r.head_direction <= ahtc_pkg::RESET_DIRECTION;
            r.head_angle <= ahtc_pkg::RESET_ANGLE;
            r.held_angle <= ahtc_pkg::RESET_ANGLE;
            r.prev_angle <= ahtc_pkg::RESET_ANGLE;
            r.acc <= ahtc_pkg::RESET_ACC;
            r.turns <= 12'h000;
            r.total_position <= 24'h00_0000;
            r.held_angle_out <= 12'h000;
        end
        else if (clock_enable)
        begin
            r <= next_r;
        end
    end

    // Register read port
    always_ff @(posedge clock)
    begin
        if (!rstn)
            reg_read_data <= 16'h0000;
        else if (clock_enable)
            reg_read_data <= (reg_address == ahtc_pkg::TURN_COUNT_READOUT_OFFSET) ?
                {4'h0, next_r.turns} : 16'h0000;
    end

    // Outputs from flip-flops; running is decoded from the state register
    assign angle_out = r.held_angle;
    assign held_angle_out = r.held_angle_out;
    assign head_direction = r.head_direction;
    assign position_accumulator = r.acc;
    assign turn_count_readout = r.turns;
    assign total_position = r.total_position;
    assign running = (r.state == ahtc_pkg::ST_RUN);

    // ============================================================
    // Assertions
    a_dir_after_reset: assert property (@(posedge clock)
        $past(!rstn) |-> !head_direction) else $error("Direction not zero after reset");
    a_selftest_clear: assert property (@(posedge clock)
        builtin_logic_selftest |=> !head_direction && position_accumulator == 21'h00_0000)
        else $error("Self-test did not clear state");
    a_turns_fine_map: assert property (@(posedge clock) disable iff (!rstn)
        fine_turn_mode && $stable(fine_turn_mode) |-> turn_count_readout == position_accumulator[20:9])
        else $error("Fine turn count mismatch");
    a_turns_coarse_map: assert property (@(posedge clock) disable iff (!rstn)
        !fine_turn_mode && $stable(fine_turn_mode) |->
        turn_count_readout[9:0] == position_accumulator[20:11]) else $error("Coarse turn mismatch");
    a_held_angle_12: assert property (@(posedge clock) disable iff (!rstn)
        held_angle_out == angle_out[13:2]) else $error("Held angle mismatch");
    a_hold_inside: assert property (@(posedge clock) disable iff (!rstn || builtin_logic_selftest)
        running && clock_enable && angle_valid && compensated_angle == r.head_angle |=>
        $stable(angle_out)) else $error("Output moved inside window");
    a_follow_up: assert property (@(posedge clock) disable iff (!rstn || builtin_logic_selftest)
        running && clock_enable && angle_valid && !head_direction &&
        compensated_angle == r.head_angle + 14'h0001 |=> angle_out == $past(compensated_angle))
        else $error("Output did not follow");
    a_acc_step: assert property (@(posedge clock) disable iff (!rstn || builtin_logic_selftest)
        running && clock_enable && angle_valid |=> position_accumulator == $past(next_acc_calc))
        else $error("Accumulator step wrong");
    a_freeze_acc: assert property (@(posedge clock) disable iff (!rstn || builtin_logic_selftest)
        !clock_enable |=> $stable(position_accumulator)) else $error("Accumulator moved while frozen");
    a_total_low: assert property (@(posedge clock) disable iff (!rstn)
        total_position[11:0] == held_angle_out) else $error("Total position angle wrong");
    a_total_sign: assert property (@(posedge clock) disable iff (!rstn)
        total_position[23:21] == {3{position_accumulator[20]}}) else $error("Total position sign wrong");
endmodule : ahtc_core

// ==== dv/ahtc_host_model.sv ====
// Host controller model that reads the registers of the block over its parallel address and data port
`timescale 1ns/10ps
module ahtc_host_model
(
    input wire logic clock,
    output logic [5:0] reg_address,
    input wire logic [15:0] reg_read_data
);
    // ============================================================
    // Register read access
    initial reg_address = 6'h00;
    // Select address, hold it, take registered data two cycles later
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(posedge clock);
        #2;
        reg_address = a;
        @(posedge clock);
        @(posedge clock);
        #2;
        d = reg_read_data;
    endtask : read_reg
endmodule : ahtc_host_model

// ==== dv/ahtc_core_tb.sv ====
// Self-checking testbench for the angle hysteresis and turns counter
`timescale 1ns/10ps
module ahtc_core_tb;
    logic clock, rstn, angle_valid, turns_source_select, fine_turn_mode;
    logic [13:0] compensated_angle, zero_cross_path, angle_out;
    logic [5:0] hysteresis_width, reg_address;
    logic [1:0] start_mode;
    logic [11:0] held_angle_out, turn_count_readout;
    logic head_direction, running, clock_enable, builtin_logic_selftest;
    logic [20:0] position_accumulator;
    logic [23:0] total_position;
    logic [15:0] reg_read_data, rd;
    int n_fail = 0;
    int n_compared = 0;
    // ============================================================
    // Design, host and clock
    ahtc_core dut (.clock(clock), .rstn(rstn), .clock_enable(clock_enable),
        .builtin_logic_selftest(builtin_logic_selftest), .angle_valid(angle_valid),
        .compensated_angle(compensated_angle), .zero_cross_path(zero_cross_path),
        .turns_source_select(turns_source_select), .hysteresis_width(hysteresis_width),
        .start_mode(start_mode), .fine_turn_mode(fine_turn_mode), .reg_address(reg_address),
        .angle_out(angle_out), .held_angle_out(held_angle_out),
        .head_direction(head_direction), .position_accumulator(position_accumulator),
        .turn_count_readout(turn_count_readout), .total_position(total_position),
        .reg_read_data(reg_read_data), .running(running));
    ahtc_host_model host (.clock(clock), .reg_address(reg_address),
        .reg_read_data(reg_read_data));
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // Reset for 6 cycles with the chosen start mode
    task automatic rst(input logic [1:0] m);
        @(posedge clock);
        #2;
        rstn = 1'b0;
        start_mode = m;
        repeat (6) @(posedge clock);
        #2;
        rstn = 1'b1;
    endtask : rst
    // One valid sample; compensated path parks when zero-cross path is the source
    task automatic sample(input logic [13:0] a);
        @(posedge clock);
        #2;
        zero_cross_path = a;
        compensated_angle = turns_source_select ? a : 14'h2000;
        angle_valid = 1'b1;
        @(posedge clock);
        #2;
        angle_valid = 1'b0;
        @(posedge clock);
        #2;
    endtask : sample
    // ============================================================
    // Scenarios
    task automatic s_accum();
        rst(2'b00);
        turns_source_select = 1'b0;
        sample(14'h03E8);
        chk(position_accumulator, 24'h00_0000);
        for (int i = 1; i <= 6; i++)
            sample(14'(1000 + 4000 * i)); // Passes the 0/360 wrap at step 4
        chk(position_accumulator, 24'h00_1770);
        chk(turn_count_readout, 24'h00_0002);
        chk(total_position[23:12], 24'h00_0001);
        host.read_reg(6'h2C, rd);
        chk(rd, 24'h00_0002);
        host.read_reg(6'h20, rd);
        chk(rd, 24'h00_0000);
        fine_turn_mode = 1'b1;
        sample(14'(1000 + 4000 * 6));
        chk(turn_count_readout, 24'h00_000B);
        fine_turn_mode = 1'b0;
    endtask : s_accum
    task automatic s_start();
        rst(2'b10);
        sample(14'h3000);
        chk(position_accumulator, 24'h00_0C00);
        chk(turn_count_readout, 24'h00_0001);
        rst(2'b11);
        sample(14'h3000);
        chk(position_accumulator, 24'h00_0400);
        chk(turn_count_readout, 24'h00_0000);
    endtask : s_start
    task automatic s_hys();
        rst(2'b00);
        chk({angle_out, head_direction}, 24'h00_0000);
        turns_source_select = 1'b1;
        hysteresis_width = 6'h08;
        sample(14'h0064);
        sample(14'h0060);
        chk({angle_out, head_direction}, {14'h0064, 1'b0});
        sample(14'h00C8);
        chk(angle_out, 24'h00_00C8);
        chk(held_angle_out, 24'h00_0032);
        sample(14'h00C4);
        chk({angle_out, head_direction}, {14'h00C8, 1'b0});
        sample(14'h00BE);
        chk(head_direction, 24'h00_0001);
    endtask : s_hys
    // Backward turn, frozen clock enable, then self-test clear
    task automatic s_misc();
        rst(2'b00);
        turns_source_select = 1'b1;
        hysteresis_width = 6'h00;
        sample(14'h1000);
        sample(14'h0000);
        chk(position_accumulator, 24'h1F_FC00);
        chk(turn_count_readout, 24'h00_0FFF);
        chk(total_position, 24'hFF_F000);
        chk(head_direction, 24'h00_0001);
        clock_enable = 1'b0;
        sample(14'h0800);
        chk({angle_out, position_accumulator}, {14'h0000, 21'h1F_FC00});
        clock_enable = 1'b1;
        @(posedge clock);
        #2;
        builtin_logic_selftest = 1'b1;
        @(posedge clock);
        #2;
        builtin_logic_selftest = 1'b0;
        chk({head_direction, position_accumulator}, 24'h00_0000);
    endtask : s_misc
    // ============================================================
    // Main sequence and watchdog
    initial
    begin
        rstn = 1'b0;
        angle_valid = 1'b0;
        compensated_angle = 14'h0000;
        zero_cross_path = 14'h0000;
        turns_source_select = 1'b1;
        hysteresis_width = 6'h00;
        start_mode = 2'b00;
        fine_turn_mode = 1'b0;
        clock_enable = 1'b1;
        builtin_logic_selftest = 1'b0;
        rst(2'b00);
        s_accum();
        s_start();
        s_hys();
        s_misc();
        give_verdict();
    end
    initial
    begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule : ahtc_core_tb
